// *** gpp_port.sv ***
// one 16-pin gpio port: data, direction, pad control and pin interrupts
`timescale 1ns/10ps
// How it works
// - four ports, same offsets, own base each
// - data reads pins, writes set outputs
// - direction bit: 0 input, 1 output; reset input
// - upper direction bits pick 10/20mA drive
// - enabled peripheral overrides pin direction
// - pad code: pull-up, reserved, schmitt, none
// - pad code 11 forces read data low
// - pad configuration reset depends on port
// - sense bit: 0 edge, 1 level
// - dual-edge bit makes both edges trigger
// - polarity: rising/high or falling/low
// - enable bit gates the irq line, not flag latching
// - raw flags readable; irq only if enabled
// - writing one to clear register clears flag; a hit in that cycle wins
// - set/reset masks touch only selected outputs
module gpp_port
   import gpp_pkg::*;
#(
   parameter int unsigned PORT_ID = 0,
   parameter int unsigned PINS = gpp_pkg::GPP_PINS
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire gpp_pkg::gpp_bus_req_s bus_req,
   output logic [31:0] bus_rdata,
   input wire logic [gpp_pkg::GPP_PINS-1:0] port_pin_in,
   output logic [gpp_pkg::GPP_PINS-1:0] port_pin_out,
   output logic [gpp_pkg::GPP_PINS-1:0] port_pin_oe,
   output gpp_pkg::gpp_pad_ctl_s pad_ctl,
   input wire logic [gpp_pkg::GPP_PINS-1:0] periph_en,
   input wire logic [gpp_pkg::GPP_PINS-1:0] periph_dir,
   output logic gpio_irq
);
   import gpp_pkg::*;

   // the register map is fixed at sixteen pins per port
   if (PORT_ID > 3) begin : gen_bad_port
      $error("gpp_port: PORT_ID must be 0..3");
   end
   if (PINS != GPP_PINS) begin : gen_bad_pins
      $error("gpp_port: PINS must be 16");
   end
   // drive bits sit above the direction bits in one word
   if (GPP_DRIVE_LSB < PINS || GPP_DRIVE_LSB + PINS > 32) begin : gen_bad_drive
      $error("gpp_port: drive field does not fit beside the direction field");
   end
   // every pin needs its pad code inside the configuration word
   if (GPP_PAD_W * PINS > 32) begin : gen_bad_pad
      $error("gpp_port: pad codes do not fit the configuration word");
   end

   // ==========================================
   // reset value and helpers

   function automatic logic [31:0] pad_reset(input int unsigned id);
      logic [31:0] v;
      v = GPP_RST_PAD_P0;
      unique case (id)
         1: v = GPP_RST_PAD_P1;
         2: v = GPP_RST_PAD_P2;
         3: v = GPP_RST_PAD_P3;
         default: v = GPP_RST_PAD_P0;
      endcase
      return v;
   endfunction

   localparam logic [31:0] PAD_RST = pad_reset(PORT_ID);

   function automatic logic [1:0] pad_code(input logic [31:0] cfg, input int unsigned pin);
      return cfg[pin*GPP_PAD_W +: GPP_PAD_W];
   endfunction

   // 16-bit field of a 32-bit word, upper bits dropped on purpose
   function automatic logic [GPP_PINS-1:0] low_half(input logic [31:0] w);
      return w[GPP_PINS-1:0];
   endfunction

   // one write strobe per register offset
   function automatic logic is_write(input gpp_bus_req_s req, input logic [GPP_AW-1:0] ofs);
      return req.wr && req.addr == ofs;
   endfunction

   // 16-bit registers read back with the upper half zero
   function automatic logic [31:0] widen(input logic [GPP_PINS-1:0] v);
      return 32'(v);
   endfunction

   // pull-up only for code 00
   function automatic logic [GPP_PINS-1:0] pull_decode(input logic [31:0] cfg);
      logic [GPP_PINS-1:0] v;
      v = '0;
      for (int i = 0; i < GPP_PINS; i++) begin
         v[i] = pad_code(cfg, i) == GPP_PAD_PULLUP;
      end
      return v;
   endfunction

   // reserved code 01 keeps the schmitt trigger on
   function automatic logic [GPP_PINS-1:0] schmitt_decode(input logic [31:0] cfg);
      logic [GPP_PINS-1:0] v;
      v = '0;
      for (int i = 0; i < GPP_PINS; i++) begin
         v[i] = pad_code(cfg, i) != GPP_PAD_RAW_LOW;
      end
      return v;
   endfunction

   localparam logic [GPP_PINS-1:0] PULL_RST = pull_decode(PAD_RST);
   localparam logic [GPP_PINS-1:0] SCHMITT_RST = schmitt_decode(PAD_RST);

   // ==========================================
   // registers

   logic [GPP_PINS-1:0] out_q;
   logic [31:0] dir_q;
   logic [31:0] pad_q;
   logic [GPP_PINS-1:0] pull_q;
   logic [GPP_PINS-1:0] schmitt_q;
   logic [GPP_PINS-1:0] sense_q;
   logic [GPP_PINS-1:0] dual_q;
   logic [GPP_PINS-1:0] pol_q;
   logic [GPP_PINS-1:0] ien_q;
   logic [GPP_PINS-1:0] raw_q;
   logic [GPP_PINS-1:0] raw_d;

   // read data
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   // pin sampling and detection
   logic [GPP_PINS-1:0] sync1_q;
   logic [GPP_PINS-1:0] sync2_q;
   logic [GPP_PINS-1:0] prev_q;
   logic [GPP_PINS-1:0] pin_val;
   logic [GPP_PINS-1:0] rise;
   logic [GPP_PINS-1:0] fall;
   logic [GPP_PINS-1:0] hit;
   logic [GPP_PINS-1:0] fclr;

   logic wr_data, wr_dir, wr_pad, wr_sense, wr_dual, wr_pol, wr_ien;
   logic wr_fclr, wr_oset, wr_orst;

   // same offset decode in every port instance
   assign wr_data = is_write(bus_req, GPP_OFS_DATA);
   assign wr_dir = is_write(bus_req, GPP_OFS_DIR);
   assign wr_pad = is_write(bus_req, GPP_OFS_PAD);
   assign wr_sense = is_write(bus_req, GPP_OFS_SENSE);
   assign wr_dual = is_write(bus_req, GPP_OFS_DUAL);
   assign wr_pol = is_write(bus_req, GPP_OFS_POL);
   assign wr_ien = is_write(bus_req, GPP_OFS_IEN);
   assign wr_fclr = is_write(bus_req, GPP_OFS_FCLR);
   assign wr_oset = is_write(bus_req, GPP_OFS_OSET);
   assign wr_orst = is_write(bus_req, GPP_OFS_ORST);

   // ==========================================
   // output data

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         out_q <= '0;
      end else if (wr_data) begin
         out_q <= low_half(bus_req.wdata);
      end else if (wr_oset) begin
         // set mask touches only its ones
         out_q <= out_q | low_half(bus_req.wdata);
      end else if (wr_orst) begin
         // reset mask touches only its ones
         out_q <= out_q & ~low_half(bus_req.wdata);
      end
   end

   // ==========================================
   // configuration registers

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dir_q <= GPP_RST_ZERO;
      end else if (wr_dir) begin
         // direction low half, drive upper half
         dir_q <= bus_req.wdata;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pad_q <= PAD_RST;
      end else if (wr_pad) begin
         pad_q <= bus_req.wdata;
      end
   end

   // pad controls decoded from the written word so they leave flip-flops
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pull_q <= PULL_RST;
         schmitt_q <= SCHMITT_RST;
      end else if (wr_pad) begin
         pull_q <= pull_decode(bus_req.wdata);
         schmitt_q <= schmitt_decode(bus_req.wdata);
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sense_q <= '0;
      end else if (wr_sense) begin
         sense_q <= low_half(bus_req.wdata);
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dual_q <= '0;
      end else if (wr_dual) begin
         dual_q <= low_half(bus_req.wdata);
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pol_q <= '0;
      end else if (wr_pol) begin
         pol_q <= low_half(bus_req.wdata);
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ien_q <= '0;
      end else if (wr_ien) begin
         ien_q <= low_half(bus_req.wdata);
      end
   end

   // ==========================================
   // pin drive and pad control

   always_comb begin
      for (int i = 0; i < GPP_PINS; i++) begin
         // no flip-flop here, so a peripheral owns its pin at once
         // peripheral direction wins when its function is on
         port_pin_oe[i] = periph_en[i] ? periph_dir[i] : dir_q[i];
      end
   end

   assign port_pin_out = out_q;

   always_comb begin
      pad_ctl.drive_hi = dir_q[GPP_DRIVE_LSB +: GPP_PINS];
      // pull and schmitt from their own flip-flops
      pad_ctl.pull_up = pull_q;
      pad_ctl.schmitt = schmitt_q;
   end

   // ==========================================
   // input sampling

   // pins are asynchronous; sync1_q feeds only sync2_q
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= port_pin_in;
         sync2_q <= sync1_q;
      end
   end

   // history holds the masked value: a high pin switched to code 11 looks like a fall
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prev_q <= '0;
      end else begin
         prev_q <= pin_val;
      end
   end

   always_comb begin
      for (int i = 0; i < GPP_PINS; i++) begin
         // input buffer off reads as low
         pin_val[i] = (pad_code(pad_q, i) == GPP_PAD_RAW_LOW) ? 1'b0 : sync2_q[i];
      end
   end

   // ==========================================
   // interrupt detection

   // edge from current versus previous sample
   assign rise = pin_val & ~prev_q;
   assign fall = ~pin_val & prev_q;

   always_comb begin
      for (int i = 0; i < GPP_PINS; i++) begin
         if (sense_q[i]) begin
            // level mode, polarity picks high or low
            hit[i] = pol_q[i] ? ~pin_val[i] : pin_val[i];
         end else if (dual_q[i]) begin
            hit[i] = rise[i] | fall[i];
         end else begin
            hit[i] = pol_q[i] ? fall[i] : rise[i];
         end
      end
   end

   assign fclr = wr_fclr ? low_half(bus_req.wdata) : '0;

   // clear by one, a fresh hit or held level wins
   always_comb begin
      for (int i = 0; i < GPP_PINS; i++) begin
         if (hit[i]) begin
            raw_d[i] = 1'b1;
         end else if (fclr[i]) begin
            raw_d[i] = 1'b0;
         end else begin
            raw_d[i] = raw_q[i];
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         raw_q <= '0;
      end else begin
         raw_q <= raw_d;
      end
   end

   // flags latch even when masked; enabling later raises the line at once
   // only enabled flagged pins reach the controller
   assign gpio_irq = |(raw_q & ien_q);

   // ==========================================
   // read path

   always_comb begin
      rdata_d = GPP_RST_ZERO;
      unique case (bus_req.addr)
         GPP_OFS_DATA: rdata_d = widen(pin_val);
         GPP_OFS_DIR: rdata_d = dir_q;
         GPP_OFS_PAD: rdata_d = pad_q;
         GPP_OFS_SENSE: rdata_d = widen(sense_q);
         GPP_OFS_DUAL: rdata_d = widen(dual_q);
         GPP_OFS_POL: rdata_d = widen(pol_q);
         GPP_OFS_IEN: rdata_d = widen(ien_q);
         GPP_OFS_RAW: rdata_d = widen(raw_q);
         // write-only and unmapped offsets read zero
         default: rdata_d = GPP_RST_ZERO;
      endcase
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= GPP_RST_ZERO;
      end else if (bus_req.rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= GPP_RST_ZERO;
      end
   end

   assign bus_rdata = rdata_q;

endmodule

// *** gpp_pkg.sv ***
// shared constants, register map and carrier types of the gpio port
package gpp_pkg;

   localparam int unsigned GPP_PINS = 16;
   localparam int unsigned GPP_AW = 8;

   // register block bases of the four ports; offsets are identical in each
   localparam logic [31:0] GPP_BASE_P0 = 32'h4004_4000;
   localparam logic [31:0] GPP_BASE_P1 = 32'h4004_6000;
   localparam logic [31:0] GPP_BASE_P2 = 32'h4004_8000;
   localparam logic [31:0] GPP_BASE_P3 = 32'h4004_a000;

   // ==========================================
   // register offsets (byte addresses in the block)
   localparam logic [GPP_AW-1:0] GPP_OFS_DATA = 8'h00;
   localparam logic [GPP_AW-1:0] GPP_OFS_DIR = 8'h04;
   localparam logic [GPP_AW-1:0] GPP_OFS_PAD = 8'h08;
   localparam logic [GPP_AW-1:0] GPP_OFS_SENSE = 8'h0c;
   localparam logic [GPP_AW-1:0] GPP_OFS_DUAL = 8'h10;
   localparam logic [GPP_AW-1:0] GPP_OFS_POL = 8'h14;
   localparam logic [GPP_AW-1:0] GPP_OFS_IEN = 8'h18;
   localparam logic [GPP_AW-1:0] GPP_OFS_RAW = 8'h1c;
   localparam logic [GPP_AW-1:0] GPP_OFS_FCLR = 8'h20;
   localparam logic [GPP_AW-1:0] GPP_OFS_OSET = 8'h24;
   localparam logic [GPP_AW-1:0] GPP_OFS_ORST = 8'h28;

   // ==========================================
   // field layout
   localparam int unsigned GPP_DRIVE_LSB = 16;
   localparam int unsigned GPP_PAD_W = 2;

   // pad configuration codes
   localparam logic [1:0] GPP_PAD_PULLUP = 2'h0;
   localparam logic [1:0] GPP_PAD_RSVD = 2'h1;
   localparam logic [1:0] GPP_PAD_SCHMITT = 2'h2;
   localparam logic [1:0] GPP_PAD_RAW_LOW = 2'h3;

   // ==========================================
   // reset values
   localparam logic [31:0] GPP_RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] GPP_RST_PAD_P0 = 32'haaaa_aaaa;
   localparam logic [31:0] GPP_RST_PAD_P1 = 32'h0000_0aaa;
   localparam logic [31:0] GPP_RST_PAD_P2 = 32'h002a_aaaa;
   localparam logic [31:0] GPP_RST_PAD_P3 = 32'h0002_aaaa;

   // ==========================================
   // carriers
   typedef struct packed {
      logic [GPP_AW-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } gpp_bus_req_s;

   typedef struct packed {
      logic [GPP_PINS-1:0] drive_hi;
      logic [GPP_PINS-1:0] pull_up;
      logic [GPP_PINS-1:0] schmitt;
   } gpp_pad_ctl_s;

endpackage

// *** gpp_port_chk.sv ***
// assertion checker for the gpio port, bound to its ports
`timescale 1ns/10ps
module gpp_port_chk
   import gpp_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire gpp_pkg::gpp_bus_req_s bus_req,
   input wire logic [31:0] bus_rdata,
   input wire logic [15:0] port_pin_out,
   input wire logic [15:0] port_pin_oe,
   input wire gpp_pkg::gpp_pad_ctl_s pad_ctl,
   input wire logic [15:0] periph_en,
   input wire logic [15:0] periph_dir,
   input wire logic gpio_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic [7:0] a;
   logic [31:0] w;
   logic wr;
   logic rd;
   assign a = bus_req.addr;
   assign w = bus_req.wdata;
   assign wr = bus_req.wr;
   assign rd = bus_req.rd;
   // ==========================================
   // register bus
   rdata_idle_a: assert property (!rd |=> bus_rdata == 32'h0)
      else $error("read data outside its slot");
   unmapped_read_a: assert property (rd && a > GPP_OFS_ORST |=> bus_rdata == 32'h0)
      else $error("unmapped offset read not zero");
   raw_upper_a: assert property (rd && a == GPP_OFS_RAW |=> bus_rdata[31:16] == 16'h0)
      else $error("raw flag upper half not zero");
   wonly_read_a: assert property (
      rd && (a == GPP_OFS_FCLR || a == GPP_OFS_OSET || a == GPP_OFS_ORST) |=> bus_rdata == 32'h0)
      else $error("write-only register read not zero");
   dir_read_a: assert property (rd && a == GPP_OFS_DIR && periph_en == 16'h0
      |=> bus_rdata == {$past(pad_ctl.drive_hi), $past(port_pin_oe)})
      else $error("direction readback wrong");
   // ==========================================
   // outputs, direction and irq masking
   data_write_a: assert property (wr && a == GPP_OFS_DATA |=> port_pin_out == $past(w[15:0]))
      else $error("data write not on outputs");
   set_mask_a: assert property (wr && a == GPP_OFS_OSET
      |=> port_pin_out == ($past(port_pin_out) | $past(w[15:0])))
      else $error("set mask wrong");
   reset_mask_a: assert property (wr && a == GPP_OFS_ORST
      |=> port_pin_out == ($past(port_pin_out) & ~$past(w[15:0])))
      else $error("reset mask wrong");
   dir_write_a: assert property (wr && a == GPP_OFS_DIR |=>
      pad_ctl.drive_hi == $past(w[31:16]) && (port_pin_oe & ~periph_en) == ($past(w[15:0]) & ~periph_en))
      else $error("direction write wrong");
   periph_dir_a: assert property ((port_pin_oe & periph_en) == (periph_dir & periph_en))
      else $error("peripheral direction not applied");
   irq_masked_a: assert property (wr && a == GPP_OFS_IEN && w[15:0] == 16'h0 |=> !gpio_irq)
      else $error("irq with all pins disabled");
endmodule
bind gpp_port gpp_port_chk chk (.core_clk, .nrst, .bus_req, .bus_rdata, .port_pin_out,
   .port_pin_oe, .pad_ctl, .periph_en, .periph_dir, .gpio_irq);

// *** gpp_pins_model.sv ***
// external circuit at the port pins
`timescale 1ns/10ps
module gpp_pins_model (
   input wire logic [15:0] oe,
   input wire logic [15:0] dout,
   input wire logic [15:0] ext,
   output logic [15:0] pin
);
   assign pin = (oe & dout) | (~oe & ext);
endmodule

// *** gpp_port_tb.sv ***
// self-checking bench for the gpio port
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module gpp_port_tb;
   import gpp_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   gpp_bus_req_s bus_req = '0;
   logic [31:0] bus_rdata;
   logic [15:0] pin_in, pin_out, pin_oe;
   logic [15:0] ext = 16'h0;
   logic [15:0] periph_en = 16'h0;
   logic [15:0] periph_dir = 16'h0;
   gpp_pad_ctl_s pad_ctl;
   logic gpio_irq;
   logic [31:0] rdata_p [1:3];
   int miscompares = 0;
   int comparisons = 0;
   logic [31:0] rst_tab [7] = '{32'h0, GPP_RST_PAD_P0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   gpp_port #(.PORT_ID(0)) dut (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .port_pin_in(pin_in), .port_pin_out(pin_out),
      .port_pin_oe(pin_oe), .pad_ctl(pad_ctl), .periph_en(periph_en),
      .periph_dir(periph_dir), .gpio_irq(gpio_irq));
   gpp_pins_model pins (.oe(pin_oe), .dout(pin_out), .ext(ext), .pin(pin_in));
   // the other three ports share the bus; only their read data are watched
   for (genvar p = 1; p < 4; p++) begin : gen_port
      gpp_port #(.PORT_ID(p)) port_inst (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req),
         .bus_rdata(rdata_p[p]), .port_pin_in(16'h0), .port_pin_out(), .port_pin_oe(),
         .pad_ctl(), .periph_en(16'h0), .periph_dir(16'h0), .gpio_irq());
   end
   always #5 core_clk = ~core_clk;
   // ==========================================
   // bus tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      #1;
      `CHK(bus_rdata, e)
   endtask
   // pin change, flag and irq, then clear and see what stays
   task automatic hit(input logic [15:0] e, input logic [15:0] r, input logic q,
      input logic [15:0] r2);
      @(posedge core_clk);
      ext <= e;
      repeat (4) @(posedge core_clk);
      #1;
      `CHK(gpio_irq, q)
      rd(GPP_OFS_RAW, {16'h0, r});
      wr(GPP_OFS_FCLR, 32'hffff);
      rd(GPP_OFS_RAW, {16'h0, r2});
   endtask
   task automatic stop_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ==========================================
   // tests
   initial begin
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      #1;
      `CHK(pad_ctl.schmitt, 16'hffff)
      `CHK(pad_ctl.pull_up, 16'h0)
      for (int i = 0; i < 7; i++) rd(8'(4 * i + 4), rst_tab[i]);
      rd(GPP_OFS_PAD, GPP_RST_PAD_P0);
      `CHK(rdata_p[1], GPP_RST_PAD_P1)
      `CHK(rdata_p[2], GPP_RST_PAD_P2)
      `CHK(rdata_p[3], GPP_RST_PAD_P3)
      rd(8'h2c, 32'h0);
      wr(8'h2c, 32'hffff_ffff);
      rd(GPP_OFS_OSET, 32'h0);
      wr(GPP_OFS_DATA, 32'h1234);
      `CHK(pin_out, 16'h1234)
      wr(GPP_OFS_OSET, 32'h0f00);
      `CHK(pin_out, 16'h1f34)
      wr(GPP_OFS_ORST, 32'h0034);
      `CHK(pin_out, 16'h1f00)
      wr(GPP_OFS_DIR, 32'h8001_00ff);
      `CHK(pin_oe, 16'h00ff)
      `CHK(pad_ctl.drive_hi, 16'h8001)
      rd(GPP_OFS_DIR, 32'h8001_00ff);
      `CHK(rdata_p[3], 32'h8001_00ff)
      @(posedge core_clk);
      periph_en <= 16'h0103;
      periph_dir <= 16'h0102;
      #1;
      `CHK(pin_oe, 16'h01fe)
      @(posedge core_clk);
      periph_en <= 16'h0;
      ext <= 16'ha5a5;
      repeat (3) @(posedge core_clk);
      rd(GPP_OFS_DATA, 32'ha500);
      wr(GPP_OFS_DIR, 32'h0);
      wr(GPP_OFS_PAD, 32'haaaa_aa1b);
      `CHK(pad_ctl.pull_up, 16'h0008)
      `CHK(pad_ctl.schmitt, 16'hfffe)
      rd(GPP_OFS_DATA, 32'ha5a4);
      wr(GPP_OFS_IEN, 32'hff00);
      wr(GPP_OFS_FCLR, 32'hffff);
      hit(16'ha7a5, 16'h0200, 1'b1, 16'h0);
      wr(GPP_OFS_POL, 32'h0800);
      hit(16'hafa5, 16'h0, 1'b0, 16'h0);
      hit(16'ha7a5, 16'h0800, 1'b1, 16'h0);
      wr(GPP_OFS_DUAL, 32'h1000);
      hit(16'hb7a5, 16'h1000, 1'b1, 16'h0);
      hit(16'ha7a5, 16'h1000, 1'b1, 16'h0);
      wr(GPP_OFS_SENSE, 32'h4000);
      hit(16'he7a5, 16'h4000, 1'b1, 16'h4000);
      hit(16'ha7a5, 16'h4000, 1'b1, 16'h0);
      wr(GPP_OFS_POL, 32'h4800);
      hit(16'ha7a5, 16'h4000, 1'b1, 16'h4000);
      hit(16'he7a5, 16'h4000, 1'b1, 16'h0);
      hit(16'he7b5, 16'h0010, 1'b0, 16'h0);
      wr(GPP_OFS_IEN, 32'h0);
      stop_test();
   end
   // about 170 cycles expected; generous margin
   initial begin
      #100us;
      miscompares++;
      stop_test();
   end
endmodule
